//--- design/channel_sequence_rate_control.sv
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "seq_rate_regs.svh"

module channel_sequence_rate_control (
   // system
   input wire logic clk_sys,
   input wire logic sys_rst,
   // conversion timing reference
   input wire logic conversion_trigger,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // converter core side
   output seq_rate_pkg::chan_t mux_channel,
   output logic conversion_active,
   output logic result_valid,
   output seq_rate_pkg::chan_t result_channel,
   output logic sequence_wrap
);
   import seq_rate_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   // only the low byte of the control word is stored; upper bits read back as zero
   // the slot memory keeps four bits per entry, so the sensor code can never be stored
   logic [15:0] seq_ctrl_reg;
   logic cmd_single_reg;
   logic [15:0] fixed_channel_enable_mask_reg;
   logic temp_include_reg;
   logic [1:0] oversample_ratio_field_reg;
   chan_t command_reg;
   chan_t cmd_pipe_reg;
   logic [3:0] custom_sequence_slot [0:`NUM_SLOTS-1];

   // sequencing state
   // pos_reg counts entries within a pass; in command modes it just rolls over
   // osr_count_reg counts conversions of the current entry towards one result
   // restart_reg holds a shape change until the core is idle
   chan_t mux_channel_reg;
   logic [6:0] pos_reg;
   logic [6:0] osr_count_reg;
   logic restart_reg;
   logic [15:0] rdata_reg;

   // decode
   logic wr_seq_ctrl;
   logic wr_cmd_ctrl;
   logic wr_fixed_mask;
   logic wr_temp_ctrl;
   logic wr_in0_config;
   logic wr_command;
   logic wr_slot;
   logic cfg_write;
   logic [6:0] slot_index;

   assign wr_seq_ctrl = reg_wr && (reg_addr == `OFS_SEQ_CTRL);
   assign wr_cmd_ctrl = reg_wr && (reg_addr == `OFS_CMD_CTRL);
   assign wr_fixed_mask = reg_wr && (reg_addr == `OFS_FIXED_MASK);
   assign wr_temp_ctrl = reg_wr && (reg_addr == `OFS_TEMP_CTRL);
   assign wr_in0_config = reg_wr && (reg_addr == `OFS_IN0_CONFIG);
   assign wr_command = reg_wr && (reg_addr == `OFS_COMMAND);
   assign wr_slot = reg_wr && reg_addr[7];
   assign slot_index = reg_addr[6:0];
   // any change to the sequence shape restarts it from the first entry
   assign cfg_write = wr_seq_ctrl | wr_cmd_ctrl | wr_fixed_mask | wr_temp_ctrl | wr_slot;

   ////////////////////////////////////////////////////////////////////////
   // mode selection
   // the select bit wins over everything else, so a stale slot field is harmless
   // while the fixed sequencer runs
   logic fixed_select;
   logic [6:0] slot_field;
   seq_mode_t mode;

   assign fixed_select = seq_ctrl_reg[`SEQ_SELECT_BIT];
   assign slot_field = seq_ctrl_reg[`SLOT_FIELD_MSB:0];
   // a zero slot field leaves the command modes selected
   assign mode = fixed_select ? MODE_FIXED :
                 (slot_field != 7'h00) ? MODE_SLOT :
                 cmd_single_reg ? MODE_ONE_CYCLE : MODE_TWO_CYCLE;

   ////////////////////////////////////////////////////////////////////////
   // oversampling ratio: 1, 4, 16 or 64 conversions per result
   // the ratio follows input zero's field for every channel of the fixed pass;
   // the other modes convert each entry once, so their rate is set by position alone
   logic [6:0] osr_last;

   assign osr_last = (mode != MODE_FIXED) ? 7'h00 :
                     (oversample_ratio_field_reg == 2'h0) ? 7'h00 :
                     (oversample_ratio_field_reg == 2'h1) ? 7'h03 :
                     (oversample_ratio_field_reg == 2'h2) ? 7'h0f : 7'h3f;

   ////////////////////////////////////////////////////////////////////////
   // conversion phase
   // the timer is the only source of phase timing; a trigger that arrives while it
   // runs is dropped, which the host must allow for when pacing triggers
   logic conv_start;
   logic conv_busy;
   logic conv_done;
   logic osr_complete;

   // a trigger during a running conversion is ignored
   assign conv_start = conversion_trigger && !conv_busy;
   // a ratio lowered mid-group ends the group at once instead of running the counter round
   assign osr_complete = (osr_count_reg >= osr_last);

   conversion_timer u_timer (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .start(conv_start),
      .busy(conv_busy),
      .done(conv_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // fixed sequencer search, temperature sensor as the top bit
   // the search is purely combinational over seventeen bits, one level per channel
   // a mask written mid-phase is seen by that phase's advance, then the restart rewinds
   chan_t fixed_next;
   chan_t fixed_first;
   logic fixed_wrap;

   fixed_channel_picker u_picker (
      .enable_mask({temp_include_reg, fixed_channel_enable_mask_reg}),
      .current(mux_channel_reg),
      .next_chan(fixed_next),
      .first_chan(fixed_first),
      .wrapped(fixed_wrap)
   );

   ////////////////////////////////////////////////////////////////////////
   // slot sequencer: slots 0..slot_field, then temperature if included
   // a field value of n gives n+1 slots, so one slot alone cannot be configured:
   // a zero field already means the command modes
   // slot_on_temp is only reached when the sensor is included, since the pass
   // otherwise wraps from the last slot
   logic slot_on_last;
   logic slot_on_temp;
   logic [6:0] pos_inc;
   chan_t slot_next_chan;
   logic [6:0] slot_next_pos;
   logic slot_wrap;

   assign pos_inc = pos_reg + 7'h01;
   assign slot_on_last = (pos_reg == slot_field);
   assign slot_on_temp = (pos_reg > slot_field);
   // slots hold four bits so the sensor cannot sit in one
   assign slot_wrap = slot_on_temp || (slot_on_last && !temp_include_reg);
   assign slot_next_pos = slot_wrap ? 7'h00 : pos_inc;
   assign slot_next_chan = slot_wrap ? {1'b0, custom_sequence_slot[0]} :
                           slot_on_last ? `TEMP_CHANNEL :
                           {1'b0, custom_sequence_slot[pos_inc]};

   ////////////////////////////////////////////////////////////////////////
   // next entry by mode
   // two-cycle commands come from cmd_pipe_reg, so each command lands one entry late
   // one-cycle commands are read straight from command_reg at the advance
   chan_t next_chan;
   logic [6:0] next_pos;
   logic next_wrap;
   chan_t first_chan;

   assign next_chan = (mode == MODE_FIXED) ? fixed_next :
                      (mode == MODE_SLOT) ? slot_next_chan :
                      (mode == MODE_ONE_CYCLE) ? command_reg : cmd_pipe_reg;
   // command modes keep counting positions with no end to the sequence
   assign next_pos = (mode == MODE_FIXED) ? (fixed_wrap ? 7'h00 : pos_inc) :
                     (mode == MODE_SLOT) ? slot_next_pos : pos_inc;
   assign next_wrap = (mode == MODE_FIXED) ? fixed_wrap :
                      (mode == MODE_SLOT) ? slot_wrap : 1'b0;
   assign first_chan = (mode == MODE_FIXED) ? fixed_first :
                       (mode == MODE_SLOT) ? {1'b0, custom_sequence_slot[0]} : command_reg;

   logic advance;
   logic apply_restart;

   // mux only moves once the oversampled group for this entry is done
   // a restart waits for both the busy phase and its done pulse to pass, so a result
   // in flight is never relabelled with the new first entry
   assign advance = conv_done && osr_complete;
   assign apply_restart = restart_reg && !conv_busy && !conv_done;

   ////////////////////////////////////////////////////////////////////////
   // configuration writes; fixed sequencer comes up selected
   // the ratio write does not restart the pass; a lowered ratio is caught by the group end check
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         seq_ctrl_reg <= `RST_SEQ_CTRL;
         cmd_single_reg <= 1'b0;
         fixed_channel_enable_mask_reg <= `RST_FIXED_MASK;
         temp_include_reg <= 1'b0;
         oversample_ratio_field_reg <= 2'h0;
         command_reg <= 5'h00;
      end else begin
         if (wr_seq_ctrl) seq_ctrl_reg <= {8'h00, reg_wdata[7:0]};
         if (wr_cmd_ctrl) cmd_single_reg <= reg_wdata[`CMD_SINGLE_BIT];
         if (wr_fixed_mask) fixed_channel_enable_mask_reg <= reg_wdata;
         if (wr_temp_ctrl) temp_include_reg <= reg_wdata[`TEMP_INCLUDE_BIT];
         if (wr_in0_config) oversample_ratio_field_reg <= reg_wdata[`OSR_FIELD_MSB:0];
         if (wr_command) command_reg <= reg_wdata[4:0];
      end
   end

   // slot memory, cleared to input zero
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         for (int i = 0; i < `NUM_SLOTS; i++) custom_sequence_slot[i] <= 4'h0;
      end else if (wr_slot) begin
         custom_sequence_slot[slot_index] <= reg_wdata[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // restart request: a new write wins over the clear
   // without that priority a write landing in the apply cycle would be lost
   always_ff @(posedge clk_sys) begin
      if (sys_rst) restart_reg <= 1'b0;
      else restart_reg <= cfg_write | (restart_reg & !apply_restart);
   end

   ////////////////////////////////////////////////////////////////////////
   // mux and position; two-cycle commands take effect one entry later
   // restart and advance never meet: a restart needs the done pulse to be low
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mux_channel_reg <= 5'h00;
         pos_reg <= 7'h00;
         cmd_pipe_reg <= 5'h00;
      end else if (apply_restart) begin
         mux_channel_reg <= first_chan;
         pos_reg <= 7'h00;
         cmd_pipe_reg <= command_reg;
      end else if (advance) begin
         mux_channel_reg <= next_chan;
         pos_reg <= next_pos;
         cmd_pipe_reg <= command_reg;
      end
   end

   // oversampling counter, one result per completed group
   always_ff @(posedge clk_sys) begin
      if (sys_rst || apply_restart) osr_count_reg <= 7'h00;
      else if (conv_done) osr_count_reg <= osr_complete ? 7'h00 : osr_count_reg + 7'h01;
   end

   ////////////////////////////////////////////////////////////////////////
   // results: one per completed oversampling group of the channel
   // result_channel is taken from the mux before it moves, so it names the input just
   // converted; sequence_wrap marks the last entry of a fixed or slot pass
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         result_valid <= 1'b0;
         result_channel <= 5'h00;
         sequence_wrap <= 1'b0;
      end else begin
         result_valid <= advance;
         sequence_wrap <= advance && next_wrap;
         if (advance) result_channel <= mux_channel_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path, data valid only the cycle after the strobe
   // the status word overlays the mux channel on its low bits; software should read
   // the channel from the mux port or mask the mode field accordingly
   // reads have no side effects, so back to back reads are safe
   logic [15:0] rd_mux;
   logic [15:0] status_word;

   assign status_word = {1'b0, pos_reg, mode, conv_busy, 1'b0, 1'b0, mux_channel_reg[4]} |
                        {11'h000, mux_channel_reg};
   assign rd_mux = reg_addr[7] ? {12'h000, custom_sequence_slot[slot_index]} :
                   (reg_addr == `OFS_SEQ_CTRL) ? seq_ctrl_reg :
                   (reg_addr == `OFS_CMD_CTRL) ? {15'h0000, cmd_single_reg} :
                   (reg_addr == `OFS_FIXED_MASK) ? fixed_channel_enable_mask_reg :
                   (reg_addr == `OFS_TEMP_CTRL) ? {15'h0000, temp_include_reg} :
                   (reg_addr == `OFS_IN0_CONFIG) ? {14'h0000, oversample_ratio_field_reg} :
                   (reg_addr == `OFS_COMMAND) ? {11'h000, command_reg} :
                   (reg_addr == `OFS_STATUS) ? status_word : 16'h0000;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) rdata_reg <= 16'h0000;
      else rdata_reg <= reg_rd ? rd_mux : 16'h0000;
   end

   assign reg_rdata = rdata_reg;
   assign mux_channel = mux_channel_reg;
   assign conversion_active = conv_busy;
endmodule : channel_sequence_rate_control

//--- design/conversion_timer.sv
`timescale 1ns/1ps
`include "seq_rate_regs.svh"

module conversion_timer (
   // system
   input wire logic clk_sys,
   input wire logic sys_rst,
   // control
   input wire logic start,
   output logic busy,
   output logic done
);
   import seq_rate_pkg::*;

   localparam logic [7:0] LAST_COUNT = 8'(`CONV_CYCLES - 1);

   conv_state_t state_reg;
   logic [7:0] count_reg;
   logic at_end;

   assign at_end = (state_reg == CONV_RUN) && (count_reg == LAST_COUNT);
   assign busy = (state_reg == CONV_RUN);

   ////////////////////////////////////////////////////////////////////////
   // conversion phase: fixed length, start ignored while running
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= CONV_IDLE;
         count_reg <= 8'h00;
         done <= 1'b0;
      end else begin
         done <= at_end;
         unique case (state_reg)
            CONV_IDLE: begin
               count_reg <= 8'h00;
               if (start) state_reg <= CONV_RUN;
            end
            CONV_RUN: begin
               count_reg <= count_reg + 8'h01;
               if (at_end) state_reg <= CONV_IDLE;
            end
            default: state_reg <= CONV_IDLE;
         endcase
      end
   end
endmodule : conversion_timer

//--- design/fixed_channel_picker.sv
`timescale 1ns/1ps
`include "seq_rate_regs.svh"

module fixed_channel_picker (
   // enabled channels, bit 16 is the temperature sensor
   input wire logic [16:0] enable_mask,
   input wire seq_rate_pkg::chan_t current,
   // search result
   output seq_rate_pkg::chan_t next_chan,
   output seq_rate_pkg::chan_t first_chan,
   output logic wrapped
);
   import seq_rate_pkg::*;

   logic [`NUM_CHANNELS:0] seen_above;
   logic [`NUM_CHANNELS:0] seen_any;
   chan_t idx_above [0:`NUM_CHANNELS];
   chan_t idx_any [0:`NUM_CHANNELS];

   assign seen_above[0] = 1'b0;
   assign seen_any[0] = 1'b0;
   assign idx_above[0] = 5'h00;
   assign idx_any[0] = 5'h00;

   ////////////////////////////////////////////////////////////////////////
   // lowest enabled channel above current, and lowest overall
   for (genvar i = 0; i < `NUM_CHANNELS; i++) begin : g_scan
      logic hit_above;
      logic take_above;
      logic take_any;
      assign hit_above = enable_mask[i] && (5'(i) > current);
      assign take_above = hit_above && !seen_above[i];
      assign take_any = enable_mask[i] && !seen_any[i];
      assign seen_above[i+1] = seen_above[i] | hit_above;
      assign seen_any[i+1] = seen_any[i] | enable_mask[i];
      assign idx_above[i+1] = take_above ? 5'(i) : idx_above[i];
      assign idx_any[i+1] = take_any ? 5'(i) : idx_any[i];
   end

   // an empty mask parks on input zero rather than stalling the mux
   assign first_chan = idx_any[`NUM_CHANNELS];
   assign wrapped = !seen_above[`NUM_CHANNELS];
   assign next_chan = wrapped ? first_chan : idx_above[`NUM_CHANNELS];
endmodule : fixed_channel_picker

//--- design/seq_rate_pkg.sv
package seq_rate_pkg;
   typedef enum logic [3:0] {
      MODE_FIXED = 4'b0001,
      MODE_SLOT = 4'b0010,
      MODE_TWO_CYCLE = 4'b0100,
      MODE_ONE_CYCLE = 4'b1000
   } seq_mode_t;

   typedef enum logic [1:0] {
      CONV_IDLE = 2'b01,
      CONV_RUN = 2'b10
   } conv_state_t;

   typedef logic [4:0] chan_t;
endpackage : seq_rate_pkg

//--- design/seq_rate_regs.svh
`ifndef SEQ_RATE_REGS_SVH
`define SEQ_RATE_REGS_SVH

// register offsets on the plain register port
`define OFS_SEQ_CTRL 8'h00
`define OFS_CMD_CTRL 8'h01
`define OFS_FIXED_MASK 8'h02
`define OFS_TEMP_CTRL 8'h03
`define OFS_IN0_CONFIG 8'h04
`define OFS_COMMAND 8'h05
`define OFS_STATUS 8'h06
`define OFS_SLOT_BASE 8'h80

// field positions
`define SEQ_SELECT_BIT 7
`define SLOT_FIELD_MSB 6
`define CMD_SINGLE_BIT 0
`define TEMP_INCLUDE_BIT 0
`define OSR_FIELD_MSB 1
`define STATUS_POS_LSB 8

// reset values
`define RST_SEQ_CTRL 16'h0080
`define RST_FIXED_MASK 16'h0001

// channel space: sixteen inputs plus the temperature sensor
`define NUM_INPUTS 16
`define NUM_CHANNELS 17
`define TEMP_CHANNEL 5'h10
`define NUM_SLOTS 128

// conversion phase timing
`define CLK_PERIOD_NS 10
`define CONV_TIME_NS 300
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- verif/seq_rate_checker_assertions.sv
`timescale 1ns/1ps
`include "seq_rate_regs.svh"
module seq_rate_checker (
   // system
   input wire logic clk_sys,
   input wire logic sys_rst,
   // timing reference
   input wire logic conversion_trigger,
   // converter side
   input wire seq_rate_pkg::chan_t mux_channel,
   input wire logic conversion_active,
   input wire logic result_valid,
   input wire seq_rate_pkg::chan_t result_channel,
   input wire logic sequence_wrap
);
   import seq_rate_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   ////////////////
   // a taken trigger opens a phase of exactly thirty cycles
   sequence s_take;
      conversion_trigger && !conversion_active;
   endsequence
   sequence s_run;
      conversion_active [*8] ##1 conversion_active [*8] ##1 conversion_active [*8] ##1 conversion_active [*6]
         ##1 !conversion_active;
   endsequence
   property p_start;
      s_take |=> s_run;
   endproperty
   a_start: assert property (p_start) else $error("conversion phase length wrong");
   // results only right after a phase ends
   property p_result;
      result_valid |-> $past(conversion_active, 2) && !$past(conversion_active);
   endproperty
   a_result: assert property (p_result) else $error("result outside phase end");
   property p_resch;
      result_valid |-> result_channel == $past(mux_channel);
   endproperty
   a_resch: assert property (p_resch) else $error("result channel not the sampled one");
   // the mux must not move under a running conversion
   property p_hold;
      conversion_active && $past(conversion_active) |-> $stable(mux_channel);
   endproperty
   a_hold: assert property (p_hold) else $error("mux moved mid conversion");
   property p_wrap;
      sequence_wrap |-> result_valid;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap without result");
   property p_range;
      mux_channel <= `TEMP_CHANNEL;
   endproperty
   a_range: assert property (p_range) else $error("mux channel out of range");
   // at least eight quiet cycles after each result
   property p_spacing;
      result_valid |=> !result_valid [*8];
   endproperty
   a_spacing: assert property (p_spacing) else $error("results too close");
   // reset is checked while it is applied, so no disable here
   property p_reset;
      disable iff (1'b0) sys_rst |=> mux_channel == 5'h00 && !conversion_active && !result_valid;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule : seq_rate_checker

//--- verif/tb_channel_sequence_rate_control.sv
`timescale 1ns/1ps
`include "seq_rate_regs.svh"
module tb_channel_sequence_rate_control;
   import seq_rate_pkg::*;
   logic clk_sys, sys_rst, reg_wr, reg_rd, req, slow, conversion_trigger;
   logic conversion_active, result_valid, sequence_wrap;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   chan_t mux_channel, result_channel;
   int mismatches, check_count, base;
   int n_conv = 0;
   chan_t fx [6] = '{5'h00, 5'h05, 5'h0a, 5'h0f, 5'h10, 5'h00};
   chan_t sl [6] = '{5'h05, 5'h09, 5'h02, 5'h05, 5'h09, 5'h10};
   ////////////////
   channel_sequence_rate_control channel_sequence_rate_control_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .conversion_trigger(conversion_trigger), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mux_channel(mux_channel), .conversion_active(conversion_active),
      .result_valid(result_valid), .result_channel(result_channel), .sequence_wrap(sequence_wrap));
   trigger_host trigger_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .slow(slow),
      .conversion_active(conversion_active), .conversion_trigger(conversion_trigger));
   // clock and count of taken triggers
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (conversion_trigger && !conversion_active) n_conv <= n_conv + 1;
   ////////////////
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // 5'h1f marks a channel the bench cannot know yet
   task automatic check_chan(input chan_t got, input chan_t exp);
      if (exp != 5'h1f) check({11'h000, got}, {11'h000, exp});
   endtask : check_chan
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 check(reg_rdata & m, exp);
   endtask : rd
   // bounded wait for one result; a last result drops the request before the host re-fires
   task automatic res(input chan_t ch, input logic w, input logic last);
      int i;
      i = 0;
      // step off the edge so the previous result pulse has cleared
      #1;
      while (result_valid !== 1'b1 && i < 3000) begin
         @(posedge clk_sys);
         #1;
         i++;
      end
      if (i >= 3000) begin
         mismatches++;
         $display("mismatch at %0t: no result", $time);
      end
      check_chan(result_channel, ch);
      check({15'h0000, sequence_wrap}, {15'h0000, w});
      @(posedge clk_sys);
      req <= !last;
   endtask : res
   task automatic cmd(input logic [15:0] c, input chan_t ch, input chan_t m);
      wr(`OFS_COMMAND, c);
      req <= 1'b1;
      res(ch, 1'b0, 1'b1);
      check_chan(mux_channel, m);
   endtask : cmd
   ////////////////
   initial begin
      #300000;
      mismatches++;
      wrap_up();
   end
   initial begin
      {sys_rst, reg_wr, reg_rd, req, slow, reg_addr, reg_wdata} = {1'b1, 28'h0};
      mismatches = 0;
      check_count = 0;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd(`OFS_SEQ_CTRL, `RST_SEQ_CTRL, 16'hffff);
      rd(`OFS_FIXED_MASK, `RST_FIXED_MASK, 16'hffff);
      rd(`OFS_STATUS, 16'h0010, 16'h00f0);
      rd(8'h07, 16'h0000, 16'hffff);
      // four inputs and the sensor, ascending, then wrap
      wr(`OFS_FIXED_MASK, 16'h8421);
      wr(`OFS_TEMP_CTRL, 16'h0001);
      req <= 1'b1;
      for (int k = 0; k < 6; k++) res(fx[k], k == 4, k == 5);
      // all seventeen entries with a slow host
      wr(`OFS_FIXED_MASK, 16'hffff);
      slow <= 1'b1;
      base = n_conv;
      req <= 1'b1;
      for (int k = 0; k < 17; k++) res(chan_t'(k), k == 16, k == 16);
      check(16'(n_conv - base), 16'h0011);
      // every ratio code on a one-entry pass
      wr(`OFS_FIXED_MASK, 16'h0001);
      wr(`OFS_TEMP_CTRL, 16'h0000);
      slow <= 1'b0;
      for (int r = 0; r < 4; r++) begin
         wr(`OFS_IN0_CONFIG, 16'(r));
         base = n_conv;
         req <= 1'b1;
         res(5'h00, 1'b1, 1'b1);
         check(16'(n_conv - base), 16'h0001 << (2 * r));
      end
      // two rates: fast 5 and 9 before each slow entry; the sensor can only join by its bit
      wr(`OFS_SEQ_CTRL, 16'h0004);
      wr(`OFS_TEMP_CTRL, 16'h0001);
      for (int k = 0; k < 5; k++) wr(`OFS_SLOT_BASE + 8'(k), {11'h000, sl[k]} | 16'h0010);
      rd(`OFS_SLOT_BASE, 16'h0005, 16'hffff);
      rd(`OFS_STATUS, 16'h0020, 16'h00e0);
      req <= 1'b1;
      for (int k = 0; k < 7; k++) res(sl[k % 6], k == 5, k == 6);
      // single-cycle commands, one channel repeated
      wr(`OFS_SEQ_CTRL, 16'h0000);
      wr(`OFS_CMD_CTRL, 16'h0001);
      rd(`OFS_STATUS, 16'h0080, 16'h00e0);
      cmd(16'h0003, 5'h00, 5'h03);
      cmd(16'h0003, 5'h03, 5'h03);
      cmd(16'h0007, 5'h03, 5'h07);
      // two-cycle commands act one advance late
      wr(`OFS_CMD_CTRL, 16'h0000);
      rd(`OFS_STATUS, 16'h0040, 16'h00e0);
      cmd(16'h0002, 5'h07, 5'h07);
      cmd(16'h0004, 5'h07, 5'h02);
      cmd(16'h0004, 5'h02, 5'h04);
      wrap_up();
   end
endmodule : tb_channel_sequence_rate_control
bind channel_sequence_rate_control seq_rate_checker seq_rate_checker_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .conversion_trigger(conversion_trigger), .mux_channel(mux_channel), .conversion_active(conversion_active),
   .result_valid(result_valid), .result_channel(result_channel), .sequence_wrap(sequence_wrap));

//--- verif/trigger_host.sv
`timescale 1ns/1ps
module trigger_host (
   // system
   input wire logic clk_sys,
   input wire logic sys_rst,
   // bench control
   input wire logic req,
   input wire logic slow,
   // device side
   input wire logic conversion_active,
   output logic conversion_trigger
);
   logic [7:0] idle_reg;
   ////////////////
   // idle gap of two or six cycles, so a stop from the bench lands before the next pulse
   // the gap is a minimum: the counter saturates, so a request after a long pause fires at once
   always_ff @(posedge clk_sys) begin
      if (sys_rst || conversion_active) begin
         idle_reg <= 8'h00;
      end else if (idle_reg != 8'hff) begin
         idle_reg <= idle_reg + 8'h01;
      end
      conversion_trigger <= !sys_rst && req && !conversion_active && idle_reg >= (slow ? 8'h06 : 8'h02);
   end
endmodule : trigger_host
